//--- hw/sccx_pkg.sv
/*
 * Package for the skip/call/clear/watchdog execute block.
 * Assumes a 14-bit instruction word and a 13-bit program counter.
 */
package sccx_pkg;
    localparam int INSN_W = 14;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;

    localparam logic [13:0] SKIP_SET_MASK = 14'h3E00;
    localparam logic [13:0] SKIP_SET_CODE = 14'h1600;
    localparam logic [13:0] CALL_MASK = 14'h3000;
    localparam logic [13:0] CALL_CODE = 14'h2000;
    localparam logic [13:0] CLR_REG_MASK = 14'h3F80;
    localparam logic [13:0] CLR_REG_CODE = 14'h0180;
    localparam logic [13:0] CLR_ACC_CODE = 14'h0140;
    localparam logic [13:0] CLR_WDOG_CODE = 14'h0004;

    localparam int BIT_POS = 6;
    localparam int CALL_TGT_W = 12;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;

    typedef enum logic [1:0] {SCCX_RUN, SCCX_CALL2, SCCX_SKIP2} sccx_state_t;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } sccx_reg_wr_t;

    typedef struct packed {
        logic zero_flag;
        logic timeout_flag;
        logic power_down_flag;
    } sccx_flags_t;

    localparam sccx_flags_t FLAGS_RESET = '{zero_flag: 1'b0, timeout_flag: 1'b1,
        power_down_flag: 1'b1};
endpackage

//--- hw/sccx_stack.sv
/*
 * Hardware return stack, registered read of the top entry.
 * Assumes push and pop are never requested together.
 */
`timescale 1ns/1ps
module sccx_stack
    import sccx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [PC_W-1:0] push_data,
    input wire logic pop,
    output logic [PC_W-1:0] stack_top
);
    logic [PC_W-1:0] mem [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [SP_W-1:0] next_sp;

    always_comb
    begin
        next_sp = sp;
        if (push)
            next_sp = sp + 3'h1;
        else if (pop)
            next_sp = sp - 3'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sp <= SP_RESET;
            stack_top <= PC_RESET;
        end
        else
        begin
            sp <= next_sp;
            if (push)
            begin
                mem[sp] <= push_data;
                stack_top <= push_data;
            end
            else if (pop)
                stack_top <= mem[sp - 3'h2];
        end
    end
endmodule

//--- hw/sccx_exec.sv
/*
 * Execute logic for skip-if-set, call, register/accumulator clear and
 * watchdog clear. Assumes one instruction offered per cycle on insn with
 * insn_valid, and the tested register byte supplied on test_byte.
 */
// Notes on behaviour
// - Skip-if-set discards the next instruction as a no-op when tested bit is one.
// - Call first pushes the address after the call onto the return stack.
// - Call then loads its 12-bit target into program counter bits 11..0.
// - Call always takes two instruction cycles.
// - Clear-register writes zero to the register and sets zero flag, one cycle.
// - Clear-accumulator writes zero to the accumulator and sets zero flag.
// - Clear-watchdog enables the watchdog and zeroes its counter, one cycle.
`timescale 1ns/1ps
module sccx_exec
    import sccx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    input wire logic [7:0] test_byte,
    input wire logic stack_pop,
    output logic [PC_W-1:0] pc,
    output logic [PC_W-1:0] stack_top,
    output logic [5:0] test_addr,
    output sccx_reg_wr_t reg_wr,
    output logic acc_clear,
    output logic [7:0] acc_value,
    output sccx_flags_t flags,
    output logic watchdog_enable,
    output logic watchdog_clear,
    output logic busy
);
    sccx_state_t state, next_state;
    logic [PC_W-1:0] next_pc;
    sccx_reg_wr_t next_reg_wr;
    logic next_acc_clear;
    logic [7:0] next_acc_value;
    sccx_flags_t next_flags;
    logic next_watchdog_enable;
    logic next_watchdog_clear;
    logic push;
    logic run;

    function automatic logic match(input logic [13:0] w, input logic [13:0] m,
                                   input logic [13:0] c);
        return (w & m) == c;
    endfunction

    assign run = insn_valid && state == SCCX_RUN;
    assign test_addr = insn[5:0];
    assign busy = state != SCCX_RUN;
    assign push = run && match(insn, CALL_MASK, CALL_CODE);

    sccx_stack u_stack (
        .clk(clk),
        .rst_n(rst_n),
        .push(push),
        .push_data(PC_W'(pc + 13'h1)),
        .pop(stack_pop),
        .stack_top(stack_top)
    );

    always_comb
    begin
        next_state = SCCX_RUN;
        next_pc = pc;
        next_reg_wr = '0;
        next_acc_clear = 1'b0;
        next_acc_value = acc_value;
        next_flags = flags;
        next_watchdog_enable = watchdog_enable;
        next_watchdog_clear = 1'b0;
        unique case (state)
            SCCX_RUN:
            begin
                if (insn_valid)
                begin
                    next_pc = PC_W'(pc + 13'h1);
                    if (match(insn, SKIP_SET_MASK, SKIP_SET_CODE))
                    begin
                        if (test_byte[insn[8:6]])
                            next_state = SCCX_SKIP2;
                    end
                    else if (push)
                    begin
                        next_pc = {pc[12], insn[CALL_TGT_W-1:0]};
                        next_state = SCCX_CALL2;
                    end
                    else if (match(insn, CLR_REG_MASK, CLR_REG_CODE))
                    begin
                        next_reg_wr.we = 1'b1;
                        next_reg_wr.addr = insn[6:0];
                        next_reg_wr.data = CLEAR_VALUE;
                        next_flags.zero_flag = 1'b1;
                    end
                    else if (insn == CLR_ACC_CODE)
                    begin
                        next_acc_clear = 1'b1;
                        next_acc_value = CLEAR_VALUE;
                        next_flags.zero_flag = 1'b1;
                    end
                    else if (insn == CLR_WDOG_CODE)
                    begin
                        next_watchdog_enable = 1'b1;
                        next_watchdog_clear = 1'b1;
                        next_flags.timeout_flag = 1'b1;
                        next_flags.power_down_flag = 1'b1;
                    end
                end
            end
            SCCX_CALL2:
                next_state = SCCX_RUN;
            SCCX_SKIP2:
            begin
                next_state = SCCX_RUN;
                if (insn_valid)
                    next_pc = PC_W'(pc + 13'h1);
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= SCCX_RUN;
            pc <= PC_RESET;
            reg_wr <= '0;
            acc_clear <= 1'b0;
            acc_value <= CLEAR_VALUE;
            flags <= FLAGS_RESET;
            watchdog_enable <= 1'b0;
            watchdog_clear <= 1'b0;
        end
        else
        begin
            state <= next_state;
            pc <= next_pc;
            reg_wr <= next_reg_wr;
            acc_clear <= next_acc_clear;
            acc_value <= next_acc_value;
            flags <= next_flags;
            watchdog_enable <= next_watchdog_enable;
            watchdog_clear <= next_watchdog_clear;
        end
    end

    sequence call_taken;
        push;
    endsequence
    sequence call_done;
        busy ##1 !busy;
    endsequence

    chk_call_two_cycles: assert property (@(posedge clk) disable iff (!rst_n)
        call_taken |=> call_done)
        else $error("call did not take two cycles");
    chk_call_target: assert property (@(posedge clk) disable iff (!rst_n)
        push |=> pc[11:0] == $past(insn[11:0]))
        else $error("call target not loaded");
    chk_call_push: assert property (@(posedge clk) disable iff (!rst_n)
        push |=> stack_top == $past(pc) + 13'h1)
        else $error("return address not pushed");
    chk_call_slot_idle: assert property (@(posedge clk) disable iff (!rst_n)
        state == SCCX_CALL2 |=> $stable(pc) && !reg_wr.we && !acc_clear && !watchdog_clear)
        else $error("second call cycle not idle");
    chk_skip_set: assert property (@(posedge clk) disable iff (!rst_n)
        run && match(insn, SKIP_SET_MASK, SKIP_SET_CODE) && test_byte[insn[8:6]]
        |=> busy ##1 !busy)
        else $error("skip not taken");
    chk_skip_clear: assert property (@(posedge clk) disable iff (!rst_n)
        run && match(insn, SKIP_SET_MASK, SKIP_SET_CODE) && !test_byte[insn[8:6]] |=> !busy)
        else $error("skip taken on clear bit");
    chk_skip_slot_nop: assert property (@(posedge clk) disable iff (!rst_n)
        state == SCCX_SKIP2 |=> !reg_wr.we && !acc_clear && !watchdog_clear && $stable(flags))
        else $error("discarded slot not a no-operation");
    chk_skip_slot_pc: assert property (@(posedge clk) disable iff (!rst_n)
        state == SCCX_SKIP2 && insn_valid |=> pc == $past(pc) + 13'h1)
        else $error("discarded slot pc step wrong");
    chk_pc_advance: assert property (@(posedge clk) disable iff (!rst_n)
        run && !push |=> pc == $past(pc) + 13'h1)
        else $error("pc did not advance");
    chk_clear_reg_zero: assert property (@(posedge clk) disable iff (!rst_n)
        run && match(insn, CLR_REG_MASK, CLR_REG_CODE)
        |=> reg_wr.we && reg_wr.data == 8'h00 && reg_wr.addr == $past(insn[6:0])
            && flags.zero_flag && !busy)
        else $error("register clear wrong");
    chk_clear_acc_zero: assert property (@(posedge clk) disable iff (!rst_n)
        run && insn == CLR_ACC_CODE |=> acc_clear && acc_value == 8'h00 && flags.zero_flag
            && !busy)
        else $error("accumulator clear wrong");
    chk_wdt_clear: assert property (@(posedge clk) disable iff (!rst_n)
        run && insn == CLR_WDOG_CODE |=> watchdog_enable && watchdog_clear && !busy)
        else $error("watchdog not restarted");
    chk_wdt_enable_held: assert property (@(posedge clk) disable iff (!rst_n)
        watchdog_enable |=> watchdog_enable)
        else $error("watchdog enable dropped");
    chk_wdt_flags: assert property (@(posedge clk) disable iff (!rst_n)
        run && insn == CLR_WDOG_CODE |=> flags.timeout_flag && flags.power_down_flag)
        else $error("watchdog flags wrong");
    chk_flags_kept: assert property (@(posedge clk) disable iff (!rst_n)
        run && (push || match(insn, SKIP_SET_MASK, SKIP_SET_CODE)) |=> $stable(flags))
        else $error("flags changed by skip or call");
endmodule

//--- verif/tb_top.sv
/*
 * Self-checking bench for the skip/call/clear execute block.
 * Assumes outputs answer on the edge that takes an instruction.
 */
`timescale 1ns/1ps
module tb_top;
    import sccx_pkg::*;
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] top;
        sccx_flags_t fl;
        sccx_reg_wr_t wr;
        logic accc;
        logic [7:0] accv;
        logic wde;
        logic wdc;
        logic busy;
        logic [5:0] ta;
    } sccx_obs_t;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic insn_valid = 1'h0;
    logic [INSN_W-1:0] insn = 14'h0000;
    logic [7:0] test_byte = 8'h00;
    logic stack_pop = 1'h0;
    logic pop_req = 1'h0;
    logic [PC_W-1:0] pc, stack_top;
    logic [5:0] test_addr;
    sccx_reg_wr_t reg_wr;
    sccx_flags_t flags;
    logic acc_clear, watchdog_enable, watchdog_clear, busy;
    logic [7:0] acc_value;
    sccx_obs_t seen;
    sccx_obs_t m = '0;
    sccx_obs_t q[$];
    sccx_state_t mst = SCCX_RUN;
    logic [PC_W-1:0] mstk [8];
    logic [2:0] msp = 3'h0;
    int mdep = 0;
    logic [5:0] seen_addr;
    int err_count = 0;
    int total_checks = 0;
    logic [31:0] rnd = 32'hDC6B;
    logic [13:0] base [6] = '{14'h1600, 14'h2000, 14'h0180, 14'h0140, 14'h0004, 14'h0700};
    logic [13:0] opm [6] = '{14'h01FF, 14'h0FFF, 14'h007F, 14'h0000, 14'h0000, 14'h00FF};
    logic [13:0] dir_i [8] = '{14'h2FFF, 14'h2123, 14'h17FF, 14'h0700, 14'h1600, 14'h01FF,
        14'h0140, 14'h0004};
    logic [7:0] dir_b [8] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h00};

    always #2.5 clk = ~clk;

    sccx_exec dut (.clk(clk), .rst_n(rst_n), .insn_valid(insn_valid), .insn(insn),
        .test_byte(test_byte), .stack_pop(stack_pop), .pc(pc), .stack_top(stack_top),
        .test_addr(test_addr), .reg_wr(reg_wr), .acc_clear(acc_clear), .acc_value(acc_value),
        .flags(flags), .watchdog_enable(watchdog_enable), .watchdog_clear(watchdog_clear),
        .busy(busy));

    assign seen = {pc, stack_top, flags, reg_wr, acc_clear, acc_value, watchdog_enable,
        watchdog_clear, busy, seen_addr};

    // Address field as taken at the edge
    always @(posedge clk)
        seen_addr <= test_addr;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic check(input sccx_obs_t s, input sccx_obs_t e);
        total_checks++;
        if (s !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One cycle of stimulus and its expected outcome
    task automatic step(input logic r, input logic v, input logic [13:0] i, input logic [7:0] b);
        logic [PC_W-1:0] old;
        #1;
        rst_n = r;
        insn_valid = v;
        insn = i;
        test_byte = b;
        stack_pop = r && pop_req && mdep > 1 && !(mst == SCCX_RUN && v && i[13:12] == 2'h2);
        old = m.pc;
        m.wr.we = 1'h0;
        m.accc = 1'h0;
        m.wdc = 1'h0;
        if (!r)
        begin
            m = '0;
            m.fl = FLAGS_RESET;
            mst = SCCX_RUN;
            msp = 3'h0;
            mdep = 0;
        end
        else if (mst == SCCX_CALL2)
            mst = SCCX_RUN;
        else if (mst == SCCX_SKIP2)
        begin
            mst = SCCX_RUN;
            if (v)
                m.pc = m.pc + 13'h0001;
        end
        else if (v)
        begin
            m.pc = m.pc + 13'h0001;
            if ((i & 14'h3E00) == 14'h1600)
                mst = b[i[8:6]] ? SCCX_SKIP2 : SCCX_RUN;
            else if (i[13:12] == 2'h2)
            begin
                m.top = m.pc;
                mstk[msp] = m.pc;
                msp = msp + 3'h1;
                if (mdep < 8)
                    mdep++;
                m.pc = {old[12], i[11:0]};
                mst = SCCX_CALL2;
            end
            else if ((i & 14'h3F80) == 14'h0180)
            begin
                m.wr = {1'h1, i[6:0], 8'h00};
                m.fl.zero_flag = 1'h1;
            end
            else if (i == 14'h0140)
            begin
                m.accc = 1'h1;
                m.accv = 8'h00;
                m.fl.zero_flag = 1'h1;
            end
            else if (i == 14'h0004)
            begin
                m.wde = 1'h1;
                m.wdc = 1'h1;
                m.fl.timeout_flag = 1'h1;
                m.fl.power_down_flag = 1'h1;
            end
        end
        // Return pops the stack
        if (stack_pop)
        begin
            m.top = mstk[msp - 3'h2];
            msp = msp - 3'h1;
            mdep--;
        end
        m.ta = i[5:0];
        m.busy = (mst != SCCX_RUN);
        @(posedge clk);
        q.push_back(m);
    endtask

    always @(negedge clk)
    begin
        sccx_obs_t s;
        sccx_obs_t e;
        if (q.size() > 0)
        begin
            e = q.pop_front();
            s = seen;
            if (e.wr.we !== 1'h1)
            begin
                s.wr = {s.wr.we, 15'h0000};
                e.wr = {e.wr.we, 15'h0000};
            end
            check(s, e);
        end
    end

    initial
    begin
        #500000;
        err_count++;
        stop_test();
    end

    initial
    begin
        for (int n = 0; n < 12; n++)
            step(1'h0, 1'h1, 14'h2000, 8'hFF);
        $display("test reset done");
        for (int n = 0; n < 8; n++)
            step(1'h1, 1'h1, dir_i[n], dir_b[n]);
        $display("test directed done");
        for (int n = 0; n < 2000; n++)
        begin
            int k;
            rnd = xs(rnd);
            k = int'(rnd[2:0]) % 6;
            pop_req = rnd[23:22] == 2'h0;
            step(rnd[31:24] != 8'h00, rnd[19:17] != 3'h0, base[k] | (rnd[16:3] & opm[k]),
                rnd[27:20]);
        end
        $display("test random done");
        for (int n = 0; n < 10 && q.size() > 0; n++)
            @(negedge clk);
        if (q.size() > 0)
            err_count++;
        stop_test();
    end
endmodule
